// file: hw/alm_limit_cmp.sv
// one hysteresis limit comparator for a single alarm channel
`timescale 1ns/1ps
module alm_limit_cmp
  import alm_pkg::*;
#(
  parameter bit HIGH = 1'b1
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // evaluation
  input wire logic eval_in,
  input wire logic signed [ALM_VAL_W-1:0] value_in,
  input wire logic signed [ALM_VAL_W-1:0] set_in,
  input wire logic signed [ALM_VAL_W-1:0] reset_in,
  // alarm
  output logic alarm_out
);

  typedef struct packed {
    logic alarm;
  } alm_cmp_state_t;

  alm_cmp_state_t state_reg;
  alm_cmp_state_t state_next;

  always_comb begin
    state_next = state_reg;
    // flag only moves at an evaluation point
    if (eval_in) begin
      if (HIGH) begin
        if (value_in > set_in) begin
          state_next.alarm = 1'b1;
        end else if (value_in < reset_in) begin
          state_next.alarm = 1'b0;
        end
      end else begin
        if (value_in < set_in) begin
          state_next.alarm = 1'b1;
        end else if (value_in > reset_in) begin
          state_next.alarm = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign alarm_out = state_reg.alarm;

endmodule

// file: hw/alm_monitor.sv
// alarm limit monitor with password-gated configuration and audit trail
`timescale 1ns/1ps

//
// Contract
// - high pressure alarm with hysteresis, default 999999
// - low pressure alarm with hysteresis, default -999999
// - high temperature alarm with hysteresis
// - low temperature alarm with hysteresis
// - high flow alarm, reset default 99990
// - low flow alarm with hysteresis
// - door alarm follows the door switch
// - door opening forces a full wake-up
// - high day volume alarm with hysteresis
// - high auxiliary pressure alarm with hysteresis
// - low auxiliary pressure alarm with hysteresis
// - protected config entry needs valid password
// - measurement continues during configuration mode
// - abort or empty confirm keeps value
// - function keys F0-F9 bind parameters
// - jump moves keep item index across sections
// - each change is audited while audit is enabled; a calibration only if no edit commits in the same cycle and the log is not full
// - audit enable sticks until full initialization
// - audit log holds at most 250 records
// - full log refuses edits until host reset
module alm_monitor
  import alm_pkg::*;
(
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // measurements
  input wire logic meas_valid_in,
  input wire alm_meas_t meas_in,
  input wire logic door_open_in,
  input wire logic [ALM_TS_W-1:0] timestamp_in,
  // host configuration
  input wire alm_cmd_t cmd_in,
  input wire logic pw_protect_in,
  // alarms and status
  output logic [ALM_NUM_CH-1:0] alarm_out,
  output logic door_alarm_out,
  output logic wake_out,
  output logic cfg_mode_out,
  output logic cfg_refused_out,
  output logic audit_full_out,
  output logic audit_enabled_out,
  output logic [ALM_AUD_W-1:0] audit_count_out,
  // audit record stream
  output logic audit_wr_out,
  output logic [ALM_TS_W-1:0] audit_ts_out,
  output logic [ALM_PAR_W-1:0] audit_addr_out,
  output logic signed [ALM_VAL_W-1:0] audit_val_out,
  output logic audit_is_cal_out,
  // parameter view
  output logic [ALM_PAR_W-1:0] view_addr_out,
  output logic signed [ALM_VAL_W-1:0] view_val_out
);

  localparam int NPAR = 2 * ALM_NUM_CH;

  typedef struct packed {
    logic [NPAR-1:0][ALM_VAL_W-1:0] limits;
    logic [ALM_FKEY_NUM-1:0][ALM_PAR_W-1:0] fkeys;
    logic cfg_mode;
    logic refused;
    logic door_alarm;
    logic door_prev;
    logic wake;
    logic audit_en;
    logic [ALM_AUD_W-1:0] audit_cnt;
    logic audit_wr;
    logic [ALM_TS_W-1:0] audit_ts;
    logic [ALM_PAR_W-1:0] audit_addr;
    logic [ALM_VAL_W-1:0] audit_val;
    logic audit_cal;
    logic [ALM_PAR_W-1:0] view_addr;
  } alm_state_t;

  alm_state_t state_reg;
  alm_state_t state_next;
  logic rst_sync1_reg;
  logic rst_sync2_reg;
  logic rst_n;
  logic audit_full;
  logic edit_commit;
  logic [ALM_PAR_W-1:0] sec_base;

  ////////////////////////////////////////////////////////////////////////////
  // reset release
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_sync1_reg <= 1'b0;
      rst_sync2_reg <= 1'b0;
    end else begin
      rst_sync1_reg <= 1'b1;
      rst_sync2_reg <= rst_sync1_reg;
    end
  end
  assign rst_n = rst_sync2_reg;

  ////////////////////////////////////////////////////////////////////////////
  // limit comparators: limits[2*i] is set point, limits[2*i+1] reset value
  // comparators run regardless of configuration mode
  for (genvar i = 0; i < ALM_NUM_CH; i++) begin : g_ch
    logic signed [ALM_VAL_W-1:0] value;
    always_comb begin
      case (i)
        CH_HI_PRES, CH_LO_PRES: value = meas_in.pres;
        CH_HI_TEMP, CH_LO_TEMP: value = meas_in.temp;
        CH_HI_FLOW, CH_LO_FLOW: value = meas_in.flow;
        CH_HI_DAYV: value = meas_in.dayv;
        default: value = meas_in.aux;
      endcase
    end
    alm_limit_cmp #(
      .HIGH(ALM_IS_HIGH[i])
    ) u_cmp (
      .clk_in(clk_in),
      .rst_n_in(rst_n),
      .eval_in(meas_valid_in),
      .value_in(value),
      .set_in(state_reg.limits[2*i]),
      .reset_in(state_reg.limits[2*i+1]),
      .alarm_out(alarm_out[i])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // configuration, edit and audit control
  assign audit_full = state_reg.audit_en && (state_reg.audit_cnt >= ALM_AUD_MAX);
  assign edit_commit = state_reg.cfg_mode && cmd_in.edit_ent && cmd_in.edit_typed
    && !cmd_in.edit_esc && (cmd_in.edit_addr < ALM_PAR_W'(NPAR));
  assign sec_base = state_reg.view_addr & ~(ALM_SEC_SIZE - 8'h01);

  always_comb begin
    state_next = state_reg;
    state_next.audit_wr = 1'b0;
    state_next.refused = 1'b0;
    state_next.door_prev = door_open_in;
    state_next.door_alarm = door_open_in;
    state_next.wake = door_open_in && !state_reg.door_prev;
    if (cmd_in.enter_cfg) begin
      if (!pw_protect_in || cmd_in.pw_ok) begin
        state_next.cfg_mode = 1'b1;
      end else begin
        state_next.refused = 1'b1;
      end
    end else if (cmd_in.exit_cfg) begin
      state_next.cfg_mode = 1'b0;
    end
    if (edit_commit) begin
      if (audit_full) begin
        state_next.refused = 1'b1;
      end else begin
        state_next.limits[cmd_in.edit_addr[4:0]] = cmd_in.edit_val;
        if (state_reg.audit_en) begin
          state_next.audit_wr = 1'b1;
          state_next.audit_cal = 1'b0;
          state_next.audit_ts = timestamp_in;
          state_next.audit_addr = cmd_in.edit_addr;
          state_next.audit_val = cmd_in.edit_val;
          state_next.audit_cnt = state_reg.audit_cnt + 8'h01;
        end
      end
    end else if (cmd_in.cal_done && state_reg.audit_en && !audit_full) begin
      state_next.audit_wr = 1'b1;
      state_next.audit_cal = 1'b1;
      state_next.audit_ts = timestamp_in;
      state_next.audit_addr = state_reg.view_addr;
      state_next.audit_val = '0;
      state_next.audit_cnt = state_reg.audit_cnt + 8'h01;
    end
    if (cmd_in.audit_reset) begin
      state_next.audit_cnt = '0;
    end
    if (cmd_in.audit_en_wr && cmd_in.audit_en_val > 8'h00) begin
      state_next.audit_en = 1'b1;
    end
    if (state_reg.cfg_mode && cmd_in.fkey_bind && cmd_in.fkey_num < ALM_FKEY_NUM) begin
      state_next.fkeys[cmd_in.fkey_num] = state_reg.view_addr;
    end
    if (cmd_in.fkey_recall && cmd_in.fkey_num < ALM_FKEY_NUM) begin
      state_next.view_addr = state_reg.fkeys[cmd_in.fkey_num];
    end else begin
      case (cmd_in.jump_nav)
        ALM_NAV_RIGHT: state_next.view_addr = state_reg.view_addr + ALM_SEC_SIZE;
        ALM_NAV_UP: state_next.view_addr = state_reg.view_addr - ALM_SEC_SIZE;
        ALM_NAV_NONE: state_next.view_addr = state_reg.view_addr;
        default: state_next.view_addr = sec_base;
      endcase
    end
    // only a full initialization clears the audit enable
    if (cmd_in.full_init) begin
      state_next.audit_en = 1'b0;
      state_next.audit_cnt = '0;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= '0;
      for (int k = 0; k < NPAR; k++) begin
        state_reg.limits[k] <= ALM_IS_HIGH[k/2] ? ALM_HI_DEF : ALM_LO_DEF;
      end
      state_reg.limits[2*CH_HI_FLOW+1] <= ALM_FLOW_RST_DEF;
    end else begin
      state_reg <= state_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign door_alarm_out = state_reg.door_alarm;
  assign wake_out = state_reg.wake;
  assign cfg_mode_out = state_reg.cfg_mode;
  assign cfg_refused_out = state_reg.refused;
  assign audit_full_out = audit_full;
  assign audit_enabled_out = state_reg.audit_en;
  assign audit_count_out = state_reg.audit_cnt;
  assign audit_wr_out = state_reg.audit_wr;
  assign audit_ts_out = state_reg.audit_ts;
  assign audit_addr_out = state_reg.audit_addr;
  assign audit_val_out = state_reg.audit_val;
  assign audit_is_cal_out = state_reg.audit_cal;
  assign view_addr_out = state_reg.view_addr;
  assign view_val_out = (state_reg.view_addr < ALM_PAR_W'(NPAR))
    ? state_reg.limits[state_reg.view_addr[4:0]] : '0;

  ////////////////////////////////////////////////////////////////////////////
  // assertions
  sequence s_open_edge;
    door_open_in && !state_reg.door_prev;
  endsequence

  door_follow_a: assert property (@(posedge clk_in) disable iff (!rst_n)
    door_open_in |=> door_alarm_out) else $error("door alarm not raised");
  wake_pulse_a: assert property (@(posedge clk_in) disable iff (!rst_n)
    s_open_edge |=> wake_out ##1 !wake_out) else $error("wake pulse wrong");
  pw_gate_a: assert property (@(posedge clk_in) disable iff (!rst_n)
    (!cfg_mode_out && cmd_in.enter_cfg && pw_protect_in && !cmd_in.pw_ok && !cmd_in.exit_cfg)
    |=> !cfg_mode_out && cfg_refused_out) else $error("entry without password");
  full_block_a: assert property (@(posedge clk_in) disable iff (!rst_n)
    (edit_commit && audit_full) |=> cfg_refused_out && !audit_wr_out)
    else $error("edit passed full log");
  count_cap_a: assert property (@(posedge clk_in) disable iff (!rst_n)
    audit_count_out <= ALM_AUD_MAX) else $error("audit count over cap");
  audit_stick_a: assert property (@(posedge clk_in) disable iff (!rst_n)
    (audit_enabled_out && !cmd_in.full_init) |=> audit_enabled_out)
    else $error("audit enable dropped");
  esc_keep_a: assert property (@(posedge clk_in) disable iff (!rst_n)
    (cmd_in.edit_esc || !cmd_in.edit_typed) |=> $stable(state_reg.limits))
    else $error("limit changed on abort");
  audit_rec_a: assert property (@(posedge clk_in) disable iff (!rst_n)
    (edit_commit && !audit_full && audit_enabled_out && !cmd_in.audit_reset
     && !cmd_in.full_init)
    |=> audit_wr_out && audit_count_out == $past(audit_count_out) + 8'h01)
    else $error("edit not audited");
  hi_pres_a: assert property (@(posedge clk_in) disable iff (!rst_n)
    (meas_valid_in && meas_in.pres > $signed(state_reg.limits[0])) |=> alarm_out[CH_HI_PRES])
    else $error("high pressure missed");
  hold_a: assert property (@(posedge clk_in) disable iff (!rst_n)
    !meas_valid_in |=> $stable(alarm_out)) else $error("alarm moved off update");

endmodule

// file: hw/alm_pkg.sv
// package for the alarm limit monitor and audit block
package alm_pkg;

  localparam int ALM_VAL_W = 24;
  localparam int ALM_NUM_CH = 9;
  localparam int ALM_PAR_W = 8;
  localparam int ALM_AUD_W = 8;
  localparam int ALM_TS_W = 32;
  localparam logic [ALM_AUD_W-1:0] ALM_AUD_MAX = 8'hFA;
  localparam logic signed [ALM_VAL_W-1:0] ALM_HI_DEF = 24'h0F423F;
  localparam logic signed [ALM_VAL_W-1:0] ALM_LO_DEF = 24'hF0BDC1;
  localparam logic signed [ALM_VAL_W-1:0] ALM_FLOW_RST_DEF = 24'h018696;
  localparam logic [3:0] ALM_FKEY_NUM = 4'hA;
  localparam logic [ALM_PAR_W-1:0] ALM_SEC_SIZE = 8'h10;

  // channel order of the limit comparators
  localparam int CH_HI_PRES = 0;
  localparam int CH_LO_PRES = 1;
  localparam int CH_HI_TEMP = 2;
  localparam int CH_LO_TEMP = 3;
  localparam int CH_HI_FLOW = 4;
  localparam int CH_LO_FLOW = 5;
  localparam int CH_HI_DAYV = 6;
  localparam int CH_HI_AUX = 7;
  localparam int CH_LO_AUX = 8;
  localparam logic [ALM_NUM_CH-1:0] ALM_IS_HIGH = 9'h0D5;

  typedef struct packed {
    logic signed [ALM_VAL_W-1:0] pres;
    logic signed [ALM_VAL_W-1:0] temp;
    logic signed [ALM_VAL_W-1:0] flow;
    logic signed [ALM_VAL_W-1:0] dayv;
    logic signed [ALM_VAL_W-1:0] aux;
  } alm_meas_t;

  typedef enum logic [1:0] {
    ALM_NAV_NONE,
    ALM_NAV_RIGHT,
    ALM_NAV_UP
  } alm_nav_t;

  typedef struct packed {
    logic enter_cfg;
    logic exit_cfg;
    logic pw_ok;
    logic edit_ent;
    logic edit_esc;
    logic edit_typed;
    logic [ALM_PAR_W-1:0] edit_addr;
    logic signed [ALM_VAL_W-1:0] edit_val;
    logic fkey_bind;
    logic fkey_recall;
    logic [3:0] fkey_num;
    alm_nav_t jump_nav;
    logic cal_done;
    logic [ALM_AUD_W-1:0] audit_en_val;
    logic audit_en_wr;
    logic audit_reset;
    logic full_init;
  } alm_cmd_t;

endpackage

// file: tb/alm_host_model.sv
// host software and measurement acquisition model feeding the monitor
`timescale 1ns/1ps
module alm_host_model
  import alm_pkg::*;
(
  // clock
  input wire logic clk_in,
  // toward the monitor
  output alm_cmd_t cmd_out,
  output logic meas_valid_out,
  output alm_meas_t meas_out,
  output logic [ALM_TS_W-1:0] ts_out
);
  initial begin
    cmd_out = '0;
    meas_valid_out = 1'h0;
    meas_out = '0;
    ts_out = 32'h00001000;
  end
  // the clock of day runs on even while the host is idle
  always @(posedge clk_in) begin
    ts_out <= ts_out + 32'h00000001;
  end
  // one idle edge before each pulse keeps back-to-back calls legal
  task automatic issue(input alm_cmd_t c, output logic [ALM_TS_W-1:0] t);
    @(posedge clk_in);
    #1;
    cmd_out = c;
    t = ts_out;
    @(posedge clk_in);
    #1;
    cmd_out = '0;
  endtask
  // values only count together with the update strobe
  task automatic sample(input alm_meas_t m, input logic v);
    @(posedge clk_in);
    #1;
    meas_out = m;
    meas_valid_out = v;
    @(posedge clk_in);
    #1;
    meas_valid_out = 1'h0;
  endtask
  // after an upload the host clears the log so edits may resume
  task automatic upload_reset();
    alm_cmd_t c;
    logic [ALM_TS_W-1:0] t;
    c = '0;
    c.audit_reset = 1'h1;
    issue(c, t);
  endtask
endmodule

// file: tb/testbench.sv
// self-checking bench for the alarm limit monitor
`timescale 1ns/1ps
module testbench;
  import alm_pkg::*;
  logic clk_in, rst_n_in, door_open_in, pw_protect_in, meas_valid;
  alm_cmd_t cmd;
  alm_meas_t meas;
  logic [ALM_TS_W-1:0] ts, aud_ts;
  logic [ALM_NUM_CH-1:0] alarm;
  logic door_alarm, wake, cfg_mode, refused, full, aud_en, aud_wr, is_cal;
  logic [ALM_AUD_W-1:0] aud_cnt;
  logic [ALM_PAR_W-1:0] aud_addr, view_addr;
  logic signed [ALM_VAL_W-1:0] aud_val, view_val;
  int miscompares = 0;
  int comparisons = 0;
  alm_host_model u_host (.clk_in(clk_in), .cmd_out(cmd), .meas_valid_out(meas_valid),
    .meas_out(meas), .ts_out(ts));
  alm_monitor u_dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .meas_valid_in(meas_valid),
    .meas_in(meas), .door_open_in(door_open_in), .timestamp_in(ts), .cmd_in(cmd),
    .pw_protect_in(pw_protect_in), .alarm_out(alarm), .door_alarm_out(door_alarm),
    .wake_out(wake), .cfg_mode_out(cfg_mode), .cfg_refused_out(refused),
    .audit_full_out(full), .audit_enabled_out(aud_en), .audit_count_out(aud_cnt),
    .audit_wr_out(aud_wr), .audit_ts_out(aud_ts), .audit_addr_out(aud_addr),
    .audit_val_out(aud_val), .audit_is_cal_out(is_cal), .view_addr_out(view_addr),
    .view_val_out(view_val));
  initial begin
    clk_in = 1'h0;
    forever #10 clk_in = ~clk_in;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic step();
    @(posedge clk_in);
    #1;
  endtask
  task automatic chk(input bit ok, input string msg);
    comparisons++;
    if (!ok) begin
      miscompares++;
      $display("MISMATCH %0t %s", $time, msg);
    end
  endtask
  task automatic complete_run();
    if (miscompares == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic send(input alm_cmd_t c);
    logic [ALM_TS_W-1:0] t;
    u_host.issue(c, t);
  endtask
  // rec says whether the edit must leave a record
  task automatic edit(input int a, input int v, input bit typed, input bit esc, input bit rec);
    alm_cmd_t c;
    logic [ALM_TS_W-1:0] t;
    c = '0;
    c.edit_ent = 1'h1;
    c.edit_typed = typed;
    c.edit_esc = esc;
    c.edit_addr = ALM_PAR_W'(a);
    c.edit_val = ALM_VAL_W'(v);
    u_host.issue(c, t);
    chk(aud_wr === rec, "record strobe");
    if (rec) begin
      chk(aud_addr === c.edit_addr && aud_val === c.edit_val, "record data");
      chk(aud_ts === t && is_cal === 1'h0, "record stamp");
    end
  endtask
  task automatic measure(input int ch, input int v, input logic valid);
    alm_meas_t m;
    m = '0;
    case (ch)
      0, 1: m.pres = ALM_VAL_W'(v);
      2, 3: m.temp = ALM_VAL_W'(v);
      4, 5: m.flow = ALM_VAL_W'(v);
      6: m.dayv = ALM_VAL_W'(v);
      default: m.aux = ALM_VAL_W'(v);
    endcase
    u_host.sample(m, valid);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_entry();
    alm_cmd_t c;
    chk(alarm === '0 && view_val === ALM_HI_DEF, "defaults");
    pw_protect_in = 1'h1;
    c = '0;
    c.enter_cfg = 1'h1;
    send(c);
    chk(refused === 1'h1 && cfg_mode === 1'h0, "entry without password");
    c.pw_ok = 1'h1;
    send(c);
    chk(cfg_mode === 1'h1 && refused === 1'h0, "entry with password");
    c = '0;
    c.audit_en_wr = 1'h1;
    for (int i = 0; i < 3; i++) begin
      c.audit_en_val = (i == 1) ? 8'h01 : 8'h00;
      send(c);
      chk(aud_en === (i > 0), "audit enable sticks");
    end
  endtask
  task automatic t_keep_nav();
    alm_cmd_t c;
    edit(0, 5, 1'h1, 1'h1, 1'h0);
    edit(0, 5, 1'h0, 1'h0, 1'h0);
    chk(view_val === ALM_HI_DEF && aud_cnt === 8'h00, "value kept");
    c = '0;
    c.jump_nav = ALM_NAV_RIGHT;
    send(c);
    chk(view_addr === 8'h10 && view_val === ALM_LO_DEF, "jump right");
    c = '0;
    c.fkey_bind = 1'h1;
    c.fkey_num = 4'h9;
    send(c);
    c = '0;
    c.jump_nav = ALM_NAV_UP;
    send(c);
    chk(view_addr === 8'h00 && view_val === ALM_HI_DEF, "jump up");
    c = '0;
    c.fkey_recall = 1'h1;
    c.fkey_num = 4'h9;
    send(c);
    chk(view_addr === 8'h10, "key recall");
    c = '0;
    c.jump_nav = ALM_NAV_UP;
    send(c);
  endtask
  task automatic t_alarms();
    int s;
    for (int ch = 0; ch < ALM_NUM_CH; ch++) begin
      s = ALM_IS_HIGH[ch] ? 100 : -100;
      edit(2 * ch, s, 1'h1, 1'h0, 1'h1);
      edit(2 * ch + 1, s / 2, 1'h1, 1'h0, 1'h1);
      measure(ch, s + s / 100, 1'h0);
      chk(alarm === '0, "no update");
      measure(ch, s + s / 100, 1'h1);
      chk(alarm === (9'h001 << ch) && cfg_mode === 1'h1, "set");
      measure(ch, s * 3 / 4, 1'h1);
      chk(alarm === (9'h001 << ch), "held");
      measure(ch, s / 2 - s / 100, 1'h1);
      chk(alarm === '0, "cleared");
    end
  endtask
  task automatic t_door();
    door_open_in = 1'h1;
    step();
    chk(door_alarm === 1'h1 && wake === 1'h1, "door opened");
    step();
    chk(door_alarm === 1'h1 && wake === 1'h0, "wake pulse");
    door_open_in = 1'h0;
    step();
    chk(door_alarm === 1'h0, "door closed");
  endtask
  task automatic t_log();
    alm_cmd_t c;
    c = '0;
    c.cal_done = 1'h1;
    send(c);
    chk(aud_wr === 1'h1 && is_cal === 1'h1 && aud_cnt === 8'h13, "cal record");
    for (int g = 0; g < 300 && aud_cnt !== ALM_AUD_MAX; g++) begin
      edit(0, 100, 1'h1, 1'h0, 1'h1);
    end
    chk(aud_cnt === ALM_AUD_MAX && full === 1'h1, "log full");
    if (full !== 1'h1) begin
      complete_run();
    end
    edit(0, 7, 1'h1, 1'h0, 1'h0);
    chk(refused === 1'h1 && aud_cnt === ALM_AUD_MAX && view_val === 100, "blocked");
    u_host.upload_reset();
    chk(aud_cnt === 8'h00 && full === 1'h0, "log cleared");
    edit(0, 7, 1'h1, 1'h0, 1'h1);
    chk(view_val === 7 && aud_cnt === 8'h01, "edit after clear");
    c = '0;
    c.full_init = 1'h1;
    send(c);
    chk(aud_en === 1'h0 && aud_cnt === 8'h00, "full init");
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    rst_n_in = 1'h0;
    door_open_in = 1'h0;
    pw_protect_in = 1'h0;
    repeat (10) step();
    rst_n_in = 1'h1;
    repeat (2) step();
    t_entry();
    t_keep_nav();
    t_alarms();
    t_door();
    t_log();
    complete_run();
  end
endmodule
